// >>> rtl/ctp_conversion_timing_power_ctrl.v
// Conversion timing, nap, power-down, global reset and channel sleep control.
// Assumes convert_start and powerdown_pin come from pins, register port on core_clk.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ctp_defines.vh"

module ctp_conversion_timing_power_ctrl #(
  parameter NUM_CH = 8,
  parameter CONV_CYCLES = `CTP_CONV_CYCLES,
  parameter WAKE_CYCLES = `CTP_WAKE_CYCLES,
  parameter POR_CYCLES = `CTP_POR_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Host pins
  input wire convert_start,
  input wire powerdown_pin,
  output wire busy,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Analog control
  output wire [NUM_CH-1:0] track_hold_n,
  output wire [NUM_CH-1:0] channel_active,
  output wire sampling_powered,
  output wire powered_down,
  output wire bandgap_enable,
  output wire buffered_reference_pin_enable,
  output wire wake_pending
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg cnv_s1_q, cnv_s2_q, cnv_s3_q;
  reg pd_s1_q, pd_s2_q, pd_s3_q;

  // Two stages then an edge stage; the second stage and the edge stage feed logic
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cnv_s1_q <= 1'b0;
      cnv_s2_q <= 1'b0;
      cnv_s3_q <= 1'b0;
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
      pd_s3_q <= 1'b0;
    end else begin
      cnv_s1_q <= convert_start;
      cnv_s2_q <= cnv_s1_q;
      cnv_s3_q <= cnv_s2_q;
      pd_s1_q <= powerdown_pin;
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
    end
  end

  wire cnv_rise = cnv_s2_q & ~cnv_s3_q;
  wire pd_rise = pd_s2_q & ~pd_s3_q;

  // ****************************************
  // Registers and state
  // ****************************************
  reg [2:0] state_q;
  reg [1:0] pwr_field_q;        // Power state field
  reg [1:0] ref_ctrl_q;         // Band-gap and buffer disable bits
  reg [NUM_CH-1:0] doze_q;      // Channel doze mask
  reg [NUM_CH-1:0] held_q;      // Channels in hold
  reg [19:0] count_q;           // Conversion or power-on timer
  reg [19:0] wake_q;            // Wake delay remaining
  reg pd_armed_q;               // A power-down entry happened since last conversion
  reg field_down_q;             // Previous field power-down level
  reg glob_rst_q;               // Global reset request

  wire field_down = (pwr_field_q == `CTP_PWR_DOWN);
  wire down_req = pd_s2_q | field_down; // R10
  wire field_rise = field_down & ~field_down_q;
  wire down_entry = pd_rise | field_rise;
  wire soft_rst = glob_rst_q;

  // Global reset fires on a second entry with no conversion between
  always @(posedge core_clk) begin
    if (!reset_n || soft_rst) begin
      pd_armed_q <= 1'b0;
      field_down_q <= 1'b0;
      glob_rst_q <= 1'b0;
    end else begin
      field_down_q <= field_down;
      glob_rst_q <= down_entry & pd_armed_q; // R18
      if (state_q == `CTP_ST_CONV)
        pd_armed_q <= 1'b0;
      else if (down_entry)
        pd_armed_q <= 1'b1;
    end
  end

  // ****************************************
  // Conversion and power state machine
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n || soft_rst) begin
      state_q <= `CTP_ST_POR; // R19
      count_q <= 20'h00000;
      wake_q <= 20'h00000;
      held_q <= {NUM_CH{1'b0}};
    end else begin
      if (wake_q != 20'h00000)
        wake_q <= wake_q - 20'h00001;
      case (state_q)
        `CTP_ST_POR: begin
          // Busy high until the power-on timer ends; its fall marks the end
          if (count_q == POR_CYCLES[19:0] - 20'h00001) begin
            state_q <= `CTP_ST_IDLE; // R13
            count_q <= 20'h00000;
            wake_q <= WAKE_CYCLES[19:0];
          end else
            count_q <= count_q + 20'h00001;
        end
        `CTP_ST_IDLE, `CTP_ST_NAP: begin
          if (down_req)
            state_q <= `CTP_ST_DOWN; // R10
          else if (cnv_rise) begin
            state_q <= `CTP_ST_CONV; // R1
            held_q <= ~doze_q; // R14
            count_q <= 20'h00000;
          end else if (state_q == `CTP_ST_IDLE && cnv_s2_q && count_q != 20'h00000)
            state_q <= `CTP_ST_NAP; // R7
        end
        `CTP_ST_CONV: begin
          // Rises during busy are ignored; pin and field cannot stop it
          if (count_q == CONV_CYCLES[19:0] - 20'h00001) begin // R2 R5 R21 R11
            held_q <= {NUM_CH{1'b0}}; // R6
            count_q <= 20'h00001;
            state_q <= down_req ? `CTP_ST_DOWN : `CTP_ST_IDLE;
          end else
            count_q <= count_q + 20'h00001;
        end
        `CTP_ST_DOWN: begin
          if (!down_req) begin
            state_q <= `CTP_ST_IDLE;
            count_q <= 20'h00000;
            wake_q <= WAKE_CYCLES[19:0];
          end
        end
        default: state_q <= `CTP_ST_POR;
      endcase
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset_n || soft_rst) begin
      pwr_field_q <= `CTP_PWR_NORMAL;
      ref_ctrl_q <= 2'h0;
      doze_q <= {NUM_CH{1'b0}}; // R15
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `CTP_ADDR_DEV_CFG: pwr_field_q <= reg_wdata[1:0];
          `CTP_ADDR_DEV_CTRL: ref_ctrl_q <= reg_wdata[1:0]; // R16
          `CTP_ADDR_DOZE: doze_q <= reg_wdata[NUM_CH-1:0]; // R20
          default: ;
        endcase
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `CTP_ADDR_DEV_CFG: reg_rdata <= {6'h00, pwr_field_q};
          `CTP_ADDR_DEV_CTRL: reg_rdata <= {6'h00, ref_ctrl_q};
          `CTP_ADDR_DOZE: reg_rdata <= doze_q;
          `CTP_ADDR_STATUS: reg_rdata <= {4'h0, (wake_q != 20'h00000), state_q};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Nap time is not acquisition: tracking resumes once pin drops (R9)
  wire in_nap = (state_q == `CTP_ST_NAP) & cnv_s2_q;
  assign busy = (state_q == `CTP_ST_CONV) | (state_q == `CTP_ST_POR); // R3
  // Mask by doze so a channel put to sleep mid-conversion leaves hold at once
  assign track_hold_n = ~(held_q & ~doze_q); // R14
  assign channel_active = ~doze_q; // R14
  assign sampling_powered = ~in_nap & (state_q != `CTP_ST_DOWN); // R7 R9
  assign powered_down = (state_q == `CTP_ST_DOWN);
  assign bandgap_enable = ~ref_ctrl_q[`CTP_BG_OFF_BIT];
  assign buffered_reference_pin_enable = ~ref_ctrl_q[`CTP_BUF_OFF_BIT];
  assign wake_pending = (wake_q != 20'h00000);

endmodule // ctp_conversion_timing_power_ctrl
`default_nettype wire

// >>> rtl/ctp_defines.vh
// Constants for the conversion timing and power-state control block.
// Assumes a 100 MHz core clock and a plain address/strobe register port.
//
// Overview of operation
// R1: Convert-start rise holds all channels, starts conversion; the code holds only channels whose doze bit is clear
// R2: Conversion always completes unless device resets
// R3: Busy high from conversion start to finish
// R4: Host lowers convert-start after 40-60 ns or busy fall
// R5: Conversion within 725 ns, acquisition at least 3465 ns
// R6: Next acquisition may start during conversion
// R7: Convert-start held high after conversion enters nap
// R8: Host holds convert-start low 750 ns leaving nap
// R9: In nap, acquisition equals convert-start low time
// R10: Pin or field value 3 powers down, ignores requests
// R11: Power-down during conversion waits for its completion
// R12: Host waits 1 ms after power-down pin falls
// R13: Busy falls at power-on reset end; host waits 1 ms
// R14: Sleeping channel stands by and ignores conversions
// R15: Sleep off after reset; mask bit sleeps channel
// R16: Control bits disable band-gap and reference buffer
// R17: Host keeps digital lines quiet before convert rise
// R18: Two power-down rises without conversion reset device
// R19: Reset halts conversion, restores all defaults
// R20: Sleep mask bit n controls channel n
// R21: Convert-start rises while busy are ignored
`ifndef CTP_DEFINES_VH
`define CTP_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define CTP_CLK_PERIOD_NS 10
`define CTP_CONV_TIME_NS 725
`define CTP_CONV_CYCLES (`CTP_CONV_TIME_NS / `CTP_CLK_PERIOD_NS)
`define CTP_WAKE_TIME_US 1000
`define CTP_WAKE_CYCLES (`CTP_WAKE_TIME_US * 1000 / `CTP_CLK_PERIOD_NS)
`define CTP_POR_TIME_NS 1000
`define CTP_POR_CYCLES (`CTP_POR_TIME_NS / `CTP_CLK_PERIOD_NS)

// ****************************************
// Register map
// ****************************************
`define CTP_ADDR_DEV_CFG 4'h0
`define CTP_ADDR_DEV_CTRL 4'h1
`define CTP_ADDR_DOZE 4'h2
`define CTP_ADDR_STATUS 4'h3
`define CTP_PWR_DOWN 2'h3
`define CTP_PWR_NORMAL 2'h0
`define CTP_BG_OFF_BIT 0
`define CTP_BUF_OFF_BIT 1

// ****************************************
// States
// ****************************************
`define CTP_ST_POR 3'h0
`define CTP_ST_IDLE 3'h1
`define CTP_ST_CONV 3'h2
`define CTP_ST_NAP 3'h3
`define CTP_ST_DOWN 3'h4

`endif

// >>> test/ctp_chk.sv
// Port checker for the conversion timing and power control block.
// Assumes it is bound to the top module and reset is synchronous.
`timescale 1ns/1ns
`default_nettype none
module ctp_chk #(parameter int CONV_CYCLES = 72) (
  // Pins and strobes
  input wire logic core_clk, reset_n, convert_start, powerdown_pin, busy, reg_wr,
  input wire logic sampling_powered, powered_down, bandgap_enable, buffered_reference_pin_enable,
  // Buses
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata, track_hold_n, channel_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] cnt_q = 16'h0; // Busy cycles so far
  logic held_q = 1'b0; // This busy run held channels
  // Power-on busy never holds a channel, which tells it apart from a conversion
  always @(posedge core_clk) begin
    cnt_q <= (reset_n && busy) ? cnt_q + 16'h1 : 16'h0;
    held_q <= reset_n && busy && (held_q || !(&track_hold_n));
  end
  a_conv_len: assert property ($fell(busy) && held_q |-> cnt_q == CONV_CYCLES)
    else $error("conversion length wrong");
  a_hold_busy: assert property (!(&track_hold_n) |-> busy)
    else $error("hold outside conversion");
  a_start_conv: assert property ($rose(convert_start) && !busy && !powerdown_pin
    && !powered_down |-> ##[1:4] busy) else $error("start not taken");
  a_down_quiet: assert property (powered_down |-> !busy && !sampling_powered)
    else $error("activity while down");
  a_finish_first: assert property (busy && held_q |-> !powered_down)
    else $error("down during conversion");
  a_nap_entry: assert property ($fell(busy) && held_q && convert_start && !powerdown_pin
    |-> ##[1:3] !sampling_powered) else $error("nap not entered");
  a_ref_write: assert property (reg_wr && reg_addr == 4'h1 |=>
    bandgap_enable == !$past(reg_wdata[0]) && buffered_reference_pin_enable == !$past(reg_wdata[1]))
    else $error("reference enables wrong");
  a_doze_write: assert property (reg_wr && reg_addr == 4'h2 |=>
    channel_active == ~$past(reg_wdata)) else $error("doze mask wrong");
  a_doze_idle: assert property ((~channel_active & ~track_hold_n) == 8'h00)
    else $error("dozing channel held");
  a_por_busy: assert property ($rose(reset_n) |-> busy[*8])
    else $error("busy low in power-on");
  c_conv: cover property ($fell(busy) && held_q);
  c_nap: cover property (!sampling_powered && !powered_down);
  c_down: cover property ($rose(powered_down));
endmodule // ctp_chk
bind ctp_conversion_timing_power_ctrl ctp_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .convert_start(convert_start), .busy(busy),
  .powerdown_pin(powerdown_pin), .reg_wr(reg_wr), .sampling_powered(sampling_powered),
  .powered_down(powered_down), .bandgap_enable(bandgap_enable), .buffered_reference_pin_enable(buffered_reference_pin_enable),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .track_hold_n(track_hold_n),
  .channel_active(channel_active));
`default_nettype wire

// >>> test/ctp_conversion_timing_power_ctrl_tb.sv
// Bench for conversion, nap, power-down, sleep and global reset.
// Assumes shortened power-on and wake counts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,a) n_compared++; if ((a) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", n, e, a); end
module ctp_conversion_timing_power_ctrl_tb;
  logic core_clk = 0, reset_n = 0, go = 0, keep = 0, powerdown_pin = 0, reg_wr = 0, reg_rd = 0;
  logic convert_start, busy, sampling_powered, powered_down, bandgap_enable, buffered_reference_pin_enable, wake;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, track_hold_n, channel_active, d;
  int n_fail = 0, n_compared = 0, cyc = 0, k, nb;
  // Address, write value, expected read value
  logic [19:0] rows [6] = '{20'h10303, 20'h10202, 20'h2A5A5, 20'h20000, 20'hF5500, 20'h30001};
  always #5 core_clk = ~core_clk;
  ctp_host_model host (.core_clk(core_clk), .go(go), .keep(keep), .convert_start(convert_start));
  ctp_conversion_timing_power_ctrl #(.WAKE_CYCLES(50), .POR_CYCLES(10)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .convert_start(convert_start), .busy(busy),
    .powerdown_pin(powerdown_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .track_hold_n(track_hold_n),
    .channel_active(channel_active), .sampling_powered(sampling_powered),
    .powered_down(powered_down), .bandgap_enable(bandgap_enable),
    .buffered_reference_pin_enable(buffered_reference_pin_enable), .wake_pending(wake));
  task complete_run;
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cut a hang short well past the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin n_fail++; complete_run; end
  end
  task tick(int n); repeat (n) @(posedge core_clk); endtask
  task wr(logic [3:0] a, logic [7:0] v);
    @(posedge core_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge core_clk); reg_wr <= 0;
  endtask
  task rd(logic [3:0] a);
    @(posedge core_clk); reg_rd <= 1; reg_addr <= a;
    @(posedge core_clk); reg_rd <= 0;
    @(negedge core_clk); d = reg_rdata;
  endtask
  task wait_busy(logic v);
    for (k = 0; k < 300 && busy !== v; k++) @(negedge core_clk);
    `CHK("busy", v, busy)
  endtask
  // Only the start request moves here; register strobes stay quiet around it
  task pulse; @(posedge core_clk); go <= 1; @(posedge core_clk); go <= 0; endtask
  initial begin
    tick(20); reset_n <= 1;
    rd(4'h2); `CHK("doze", 8'h00, d)
    `CHK("bandgap", 1'b1, bandgap_enable)
    wait_busy(0); tick(60);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]); rd(rows[i][19:16]);
      `CHK("reg", rows[i][7:0], d)
    end
    `CHK("buffered_reference_pin", 1'b0, buffered_reference_pin_enable)
    pulse; wait_busy(1); nb = 1;
    for (k = 0; k < 200 && busy === 1; k++) @(negedge core_clk) nb += busy;
    `CHK("conv", 72, nb)
    pulse; wait_busy(1); tick(20); pulse; tick(56); `CHK("busy", 1'b0, busy)
    keep <= 1; pulse; wait_busy(1); wait_busy(0); tick(4);
    `CHK("sampling", 1'b0, sampling_powered)
    keep <= 0; tick(76); pulse; wait_busy(1); wait_busy(0);
    pulse; wait_busy(1); powerdown_pin <= 1; tick(5);
    `CHK("down", 1'b0, powered_down)
    wait_busy(0); tick(4); `CHK("down", 1'b1, powered_down)
    pulse; tick(8); `CHK("busy", 1'b0, busy)
    powerdown_pin <= 0; tick(4); `CHK("wake", 1'b1, wake)
    tick(60); pulse; wait_busy(1); wait_busy(0);
    wr(4'h0, 8'h03); tick(4); `CHK("down", 1'b1, powered_down)
    wr(4'h0, 8'h00); tick(60); wr(4'h2, 8'h0F); @(negedge core_clk);
    `CHK("active", 8'hF0, channel_active)
    @(posedge core_clk); powerdown_pin <= 1; tick(5); `CHK("busy", 1'b1, busy)
    powerdown_pin <= 0; wait_busy(0); rd(4'h2); `CHK("doze", 8'h00, d)
    complete_run;
  end
endmodule // ctp_conversion_timing_power_ctrl_tb
`default_nettype wire

// >>> test/ctp_host_model.sv
// Host side model that drives the convert-start pin.
// Assumes go is a one-cycle request and keep asks for nap.
`timescale 1ns/1ns
`default_nettype none
module ctp_host_model (
  // Clock and requests
  input wire logic core_clk, go, keep,
  // Pin to the device
  output var logic convert_start
);
  logic [2:0] left_q = 3'h0; // High cycles still owed
  initial convert_start = 1'b0;
  // High for 50 ns, then low unless nap is wanted
  always @(posedge core_clk) begin
    if (go) begin
      convert_start <= 1'b1;
      left_q <= 3'h4;
    end else if (left_q != 3'h0) left_q <= left_q - 3'h1;
    else if (!keep) convert_start <= 1'b0;
  end
endmodule // ctp_host_model
`default_nettype wire
